// file: shared/cpd_pkg.sv
package cpd_pkg;

  // Bus widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_COUNT = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_MAP0 = 8'h10;
  localparam logic [7:0] MAP_STEP = 8'h04;

  // Control register fields
  localparam int CTRL_FMT_LSB = 0;
  localparam int CTRL_INV_BIT = 2;
  localparam int CTRL_MODE_LSB = 4;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // Status register fields
  localparam int ST_PIN_LSB = 0;
  localparam int ST_DIR_BIT = 8;
  localparam int ST_PERR_BIT = 9;
  localparam int ST_FUNC_LSB = 16;

  // Pulse formats
  localparam logic [1:0] FMT_QUAD0 = 2'h0;
  localparam logic [1:0] FMT_DUAL = 2'h1;
  localparam logic [1:0] FMT_QUAD2 = 2'h2;
  localparam logic [1:0] FMT_PDIR = 2'h3;

  // Control modes
  localparam logic [1:0] MODE_POS = 2'h0;
  localparam logic [1:0] MODE_FULL = 2'h1;
  localparam logic [1:0] MODE_VEL = 2'h2;
  localparam logic [1:0] MODE_TRQ = 2'h3;

  // Input pins and functions
  localparam int NPIN = 5;
  localparam int FUNC_W = 4;
  localparam int NFUNC = 16;
  localparam logic [3:0] FN_NONE = 4'h0;
  localparam logic [3:0] FN_NEG_TRAVEL = 4'h1;
  localparam logic [3:0] FN_POS_TRAVEL = 4'h2;
  localparam logic [3:0] FN_SPEED_ZERO = 4'h3;
  localparam logic [3:0] FN_GAIN_SWITCH = 4'h4;
  localparam logic [3:0] FN_SPEED_SEL3 = 4'h5;

  // Pin map register fields: code and normally-closed flag per mode group
  localparam int MAP_POS_LSB = 0;
  localparam int MAP_POS_NC = 4;
  localparam int MAP_VEL_LSB = 8;
  localparam int MAP_VEL_NC = 12;
  localparam int MAP_TRQ_LSB = 16;
  localparam int MAP_TRQ_NC = 20;
  localparam logic [31:0] MAP_MASK = 32'h001F_1F1F;
  localparam logic [NPIN-1:0][31:0] MAP_RESET = '{
    32'h0000_0000,
    32'h0000_0500,
    32'h0004_0404,
    32'h0013_1300,
    32'h0012_1212
  };

  // Timing: least separation of edges on the fast interface
  localparam int CLK_PERIOD_NS = 50;
  localparam int MIN_EDGE_NS = 125;
  localparam int MIN_EDGE_CYC =
    (MIN_EDGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic [2:0] awprot;
    logic wvalid;
    logic [DATA_W-1:0] wdata;
    logic [STRB_W-1:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic [2:0] arprot;
    logic rready;
  } cpd_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } cpd_axi_rsp_t;

  typedef struct packed {
    logic aw_ok;
    logic [ADDR_W-1:0] awaddr;
    logic w_ok;
    logic [DATA_W-1:0] wdata;
    logic [STRB_W-1:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
    logic [1:0] fmt;
    logic inv;
    logic [1:0] mode;
    logic [NPIN-1:0][31:0] map;
    logic puls_q;
    logic sign_q;
    logic [31:0] count;
    logic step;
    logic step_neg;
    logic perr;
    logic [NFUNC-1:0] func;
  } cpd_state_t;

endpackage

// file: src/cpd_func_sel.sv
// Raises one function when any pin carrying its code is in the on state
module cpd_func_sel #(
  parameter logic [3:0] CODE = 4'h1
) (
  // Per-pin state
  input logic [cpd_pkg::NPIN-1:0] pin_on_i,
  input logic [cpd_pkg::NPIN-1:0][3:0] pin_code_i,
  // Result
  output logic active_o
);

  // Several pins may share one function; any of them turns it on
  always_comb begin
    active_o = 1'b0;
    for (int i = 0; i < cpd_pkg::NPIN; i++) begin
      if (pin_code_i[i] == CODE && pin_on_i[i]) begin
        active_o = 1'b1;
      end
    end
  end

endmodule // cpd_func_sel

// file: src/cpd_top.sv
// What this block does
// R1: Formats 0 and 2 decode quadrature direction.
// R2: Inversion setting swaps quadrature count direction.
// R3: Formats 1 and 3 step on rising edge.
// R4: Quadrature counts every edge, four per cycle.
// R5: Decoder uses only pulse and sign inputs.
// R6: Resolve edges 0.125 us apart, 8 Mpulse/s.
// R7: Any function maps onto any input pin.
// R8: Each input pin's active logic is selectable.
// R9: Pulses ignored in velocity and torque modes.
// R10: Normally-open on when connected; closed opposite.
// R11: Separate pin maps per control mode group.
// R12: Host keeps sign stable, widths within limits.
module cpd_top (
  // Clock and reset
  input logic clk_sys_i,
  input logic sys_rst_i,
  // Register bus
  input cpd_pkg::cpd_axi_req_t axi_req_i,
  output cpd_pkg::cpd_axi_rsp_t axi_rsp_o,
  // Conditioned command inputs
  input logic pulse_i,
  input logic sign_i,
  // General inputs, high when connected to common
  input logic [cpd_pkg::NPIN-1:0] general_input_i,
  // Decoded command
  output logic step_o,
  output logic step_neg_o,
  output logic [31:0] position_count_o,
  // Function outputs, bit index is the function code
  output logic [cpd_pkg::NFUNC-1:0] func_o
);

  cpd_pkg::cpd_state_t s;
  cpd_pkg::cpd_state_t next_s;
  logic pos_mode;
  logic a_ch;
  logic b_ch;
  logic a_lead;
  logic p_rise;
  logic s_rise;
  logic dec_step;
  logic dec_neg;
  logic clear_now;
  logic [cpd_pkg::NPIN-1:0] pin_on;
  logic [cpd_pkg::NPIN-1:0][3:0] pin_code;
  logic [cpd_pkg::NPIN-1:0] pin_nc;
  logic [cpd_pkg::NFUNC-1:0] func_act;
  logic [31:0] ctrl_word;
  logic [31:0] status_word;
  logic [31:0] ctrl_merged;

  // Merge write data into a word under the byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = data[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Handshake outputs straight from state
  always_comb begin
    axi_rsp_o.awready = !s.aw_ok && !s.bvalid;
    axi_rsp_o.wready = !s.w_ok && !s.bvalid;
    axi_rsp_o.bvalid = s.bvalid;
    axi_rsp_o.bresp = s.bresp;
    axi_rsp_o.arready = !s.rvalid;
    axi_rsp_o.rvalid = s.rvalid;
    axi_rsp_o.rdata = s.rdata;
    axi_rsp_o.rresp = s.rresp;
  end

  // Readable words built from state; the status word also takes the live pin levels
  always_comb begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[cpd_pkg::CTRL_FMT_LSB +: 2] = s.fmt;
    ctrl_word[cpd_pkg::CTRL_INV_BIT] = s.inv;
    ctrl_word[cpd_pkg::CTRL_MODE_LSB +: 2] = s.mode;
    status_word = 32'h0000_0000;
    status_word[cpd_pkg::ST_PIN_LSB +: cpd_pkg::NPIN] = general_input_i;
    status_word[cpd_pkg::ST_DIR_BIT] = s.step_neg;
    status_word[cpd_pkg::ST_PERR_BIT] = s.perr;
    status_word[cpd_pkg::ST_FUNC_LSB +: cpd_pkg::NFUNC] = s.func;
  end

  // Command decoder; only the pulse and sign lines feed it [R5]
  always_comb begin
    pos_mode = (s.mode == cpd_pkg::MODE_POS) ||
               (s.mode == cpd_pkg::MODE_FULL);
    a_ch = pulse_i ^ s.puls_q;
    b_ch = sign_i ^ s.sign_q;
    // A leads B when A moves away from B or B moves onto A [R1]
    a_lead = a_ch ? (pulse_i != sign_i) : (sign_i == pulse_i);
    p_rise = pulse_i && !s.puls_q;
    s_rise = sign_i && !s.sign_q;
    dec_step = 1'b0;
    dec_neg = 1'b0;
    case (s.fmt)
      cpd_pkg::FMT_QUAD0, cpd_pkg::FMT_QUAD2: begin
        // Every edge of either phase counts; a double change is lost [R4]
        dec_step = a_ch ^ b_ch;
        dec_neg = a_lead ^ s.inv; // [R2]
      end
      cpd_pkg::FMT_DUAL: begin
        // Pulse line forward, sign line reverse, rising edges only [R3]
        dec_step = p_rise ^ s_rise;
        dec_neg = s_rise ^ s.inv;
      end
      cpd_pkg::FMT_PDIR: begin
        // Sign level gives direction, sampled with the rising edge [R3] [R12]
        dec_step = p_rise;
        dec_neg = sign_i ^ s.inv;
      end
      default: dec_step = 1'b0;
    endcase
    // No position command outside position and full-closed modes [R9]
    dec_step = dec_step && pos_mode;
  end

  // Pin map selection by the active control mode [R11]
  always_comb begin
    for (int i = 0; i < cpd_pkg::NPIN; i++) begin
      case (s.mode)
        cpd_pkg::MODE_VEL: begin
          pin_code[i] = s.map[i][cpd_pkg::MAP_VEL_LSB +: 4];
          pin_nc[i] = s.map[i][cpd_pkg::MAP_VEL_NC];
        end
        cpd_pkg::MODE_TRQ: begin
          pin_code[i] = s.map[i][cpd_pkg::MAP_TRQ_LSB +: 4];
          pin_nc[i] = s.map[i][cpd_pkg::MAP_TRQ_NC];
        end
        default: begin
          pin_code[i] = s.map[i][cpd_pkg::MAP_POS_LSB +: 4];
          pin_nc[i] = s.map[i][cpd_pkg::MAP_POS_NC];
        end
      endcase
      // Open contact reads off, closed contact flips it [R8] [R10]
      pin_on[i] = general_input_i[i] ^ pin_nc[i];
    end
  end

  // One selector per function code; code zero means unassigned [R7]
  assign func_act[0] = 1'b0;
  for (genvar f = 1; f < cpd_pkg::NFUNC; f++) begin : g_func
    cpd_func_sel #(
      .CODE(4'(f))
    ) u_sel (
      .pin_on_i(pin_on),
      .pin_code_i(pin_code),
      .active_o(func_act[f])
    );
  end

  // Next state: bus slave, counter and input sampling
  always_comb begin
    next_s = s;
    clear_now = 1'b0;
    ctrl_merged = 32'h0000_0000;
    if (s.bvalid && axi_req_i.bready) begin
      next_s.bvalid = 1'b0;
    end
    if (s.rvalid && axi_req_i.rready) begin
      next_s.rvalid = 1'b0;
    end
    // Address and data are taken in either order
    if (axi_req_i.awvalid && axi_rsp_o.awready) begin
      next_s.aw_ok = 1'b1;
      next_s.awaddr = axi_req_i.awaddr;
    end
    if (axi_req_i.wvalid && axi_rsp_o.wready) begin
      next_s.w_ok = 1'b1;
      next_s.wdata = axi_req_i.wdata;
      next_s.wstrb = axi_req_i.wstrb;
    end
    // The write lands once both halves are held
    if (next_s.aw_ok && next_s.w_ok) begin
      next_s.aw_ok = 1'b0;
      next_s.w_ok = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = cpd_pkg::RESP_OKAY;
      case (next_s.awaddr)
        cpd_pkg::OFS_CTRL: begin
          // Merge first: a function result cannot be sliced directly
          ctrl_merged = merge(ctrl_word, next_s.wdata, next_s.wstrb);
          next_s.fmt = ctrl_merged[cpd_pkg::CTRL_FMT_LSB +: 2];
          next_s.inv = ctrl_merged[cpd_pkg::CTRL_INV_BIT];
          next_s.mode = ctrl_merged[cpd_pkg::CTRL_MODE_LSB +: 2];
        end
        cpd_pkg::OFS_COUNT: begin
          clear_now = |next_s.wstrb;
        end
        cpd_pkg::OFS_STATUS: begin
          // Phase error is write-one-to-clear
          if (next_s.wstrb[1] && next_s.wdata[cpd_pkg::ST_PERR_BIT]) begin
            next_s.perr = 1'b0;
          end
        end
        default: begin
          next_s.bresp = cpd_pkg::RESP_SLVERR;
          for (int i = 0; i < cpd_pkg::NPIN; i++) begin
            if (next_s.awaddr == cpd_pkg::OFS_MAP0 +
                8'(i) * cpd_pkg::MAP_STEP) begin
              next_s.bresp = cpd_pkg::RESP_OKAY;
              next_s.map[i] = merge(s.map[i], next_s.wdata,
                                    next_s.wstrb) & cpd_pkg::MAP_MASK;
            end
          end
        end
      endcase
    end
    // Reads answer from current state; unmapped reads give zero and error
    if (axi_req_i.arvalid && axi_rsp_o.arready) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = cpd_pkg::RESP_OKAY;
      case (axi_req_i.araddr)
        cpd_pkg::OFS_CTRL: next_s.rdata = ctrl_word;
        cpd_pkg::OFS_COUNT: next_s.rdata = s.count;
        cpd_pkg::OFS_STATUS: next_s.rdata = status_word;
        default: begin
          next_s.rdata = 32'h0000_0000;
          next_s.rresp = cpd_pkg::RESP_SLVERR;
          for (int i = 0; i < cpd_pkg::NPIN; i++) begin
            if (axi_req_i.araddr == cpd_pkg::OFS_MAP0 +
                8'(i) * cpd_pkg::MAP_STEP) begin
              next_s.rdata = s.map[i];
              next_s.rresp = cpd_pkg::RESP_OKAY;
            end
          end
        end
      endcase
    end
    // Sample every cycle: at 50 ns each 125 ns edge is seen once [R6]
    next_s.puls_q = pulse_i;
    next_s.sign_q = sign_i;
    next_s.step = dec_step;
    if (dec_step) begin
      next_s.step_neg = dec_neg;
    end
    // A step in the clearing cycle still counts from zero
    if (clear_now) begin
      next_s.count = 32'h0000_0000;
    end
    if (dec_step) begin
      next_s.count = next_s.count + (dec_neg ? 32'hFFFF_FFFF : 32'h0000_0001);
    end
    // Both quadrature phases moving in one sample is an illegal step
    if (pos_mode && a_ch && b_ch &&
        (s.fmt == cpd_pkg::FMT_QUAD0 || s.fmt == cpd_pkg::FMT_QUAD2)) begin
      next_s.perr = 1'b1;
    end
    next_s.func = func_act;
  end

  // State register
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s <= '0;
      s.fmt <= cpd_pkg::CTRL_RESET[cpd_pkg::CTRL_FMT_LSB +: 2];
      s.map <= cpd_pkg::MAP_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign step_o = s.step;
  assign step_neg_o = s.step_neg;
  assign position_count_o = s.count;
  assign func_o = s.func;

  // Checks on bus write answer, decoder and pin mapping
  logic quad_fmt;
  assign quad_fmt = (s.fmt == cpd_pkg::FMT_QUAD0) ||
                    (s.fmt == cpd_pkg::FMT_QUAD2);

  sequence seq_wr_both;
    axi_req_i.awvalid && axi_rsp_o.awready &&
    axi_req_i.wvalid && axi_rsp_o.wready;
  endsequence

  a_write_answer: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    seq_wr_both |=> s.bvalid [*1] ##0 !axi_rsp_o.awready)
    else $error("write not answered");

  a_quad_every_edge: assert property ( // [R4]
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (quad_fmt && pos_mode && (a_ch ^ b_ch)) |=> step_o)
    else $error("quadrature edge not counted");

  a_quad_direction: assert property ( // [R1] [R2]
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (quad_fmt && pos_mode && a_ch && !b_ch && pulse_i != sign_i)
    |=> step_o && (step_neg_o == !$past(s.inv)))
    else $error("quadrature direction wrong");

  a_rise_steps: assert property ( // [R3]
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (s.fmt == cpd_pkg::FMT_PDIR && pos_mode && p_rise)
    |=> step_o && (step_neg_o == ($past(sign_i) ^ $past(s.inv))))
    else $error("rising edge not counted");

  a_fall_ignored: assert property ( // [R3]
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (s.fmt == cpd_pkg::FMT_PDIR && !p_rise) |=> !step_o)
    else $error("step without rising edge");

  a_count_follows: assert property ( // [R6]
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (step_o && !$past(clear_now)) |->
    position_count_o == $past(position_count_o) +
      (step_neg_o ? 32'hFFFF_FFFF : 32'h0000_0001))
    else $error("count does not follow step");

  a_mode_ignore: assert property ( // [R9]
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    !pos_mode [*2] |=> !step_o)
    else $error("step outside position mode");

  a_pin_logic: assert property ( // [R8] [R10]
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (s.mode == cpd_pkg::MODE_POS && s.map[0][3:0] != cpd_pkg::FN_NONE &&
     (general_input_i[0] != s.map[0][cpd_pkg::MAP_POS_NC]))
    |=> func_o[$past(s.map[0][3:0])])
    else $error("pin logic not applied");

  a_mode_select: assert property ( // [R11] [R7]
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (s.mode == cpd_pkg::MODE_VEL && s.map[1][11:8] != cpd_pkg::FN_NONE &&
     (general_input_i[1] != s.map[1][cpd_pkg::MAP_VEL_NC]))
    |=> func_o[$past(s.map[1][11:8])])
    else $error("velocity map not applied");

endmodule // cpd_top

// file: tb/cpd_host_model.sv
// Host controller side: drives the conditioned pulse and sign lines
module cpd_host_model (
  // Clock
  input wire logic clk_sys_i,
  // Command lines
  output logic pulse_o,
  output logic sign_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Each level lasts the least edge gap rounded up to whole cycles, the fastest legal rate
  localparam int GAP = cpd_pkg::MIN_EDGE_CYC;

  // Lines idle low from time zero
  initial begin
    pulse_o = 1'b0;
    sign_o = 1'b0;
  end

  // Change both lines after a rising edge, then hold them
  task automatic put(input logic p, input logic s);
    @(posedge clk_sys_i);
    pulse_o <= p;
    sign_o <= s;
    repeat (GAP - 1) @(posedge clk_sys_i);
  endtask

  // One quadrature cycle, A leading B or B leading A
  task automatic quad(input logic a_lead);
    logic [3:0][1:0] seq;
    seq = a_lead ? 8'hB4 : 8'h78;
    for (int i = 3; i >= 0; i--) begin
      put(seq[i][1], seq[i][0]);
    end
  endtask

  // One pulse on the forward or the reverse train
  task automatic train(input logic on_sign);
    put(~on_sign, on_sign);
    put(1'b0, 1'b0);
  endtask

  // Sign is set ahead and held around the counted edge
  task automatic pdir(input logic neg);
    put(1'b0, neg);
    put(1'b1, neg);
    put(1'b0, neg);
  endtask
endmodule // cpd_host_model

// file: tb/tb_command_pulse_input_decoder.sv
// Self-checking bench for the command pulse decoder
module tb_command_pulse_input_decoder;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  cpd_pkg::cpd_axi_req_t axi_req = '0;
  cpd_pkg::cpd_axi_rsp_t axi_rsp;
  logic pulse, sign, step, step_neg;
  logic [4:0] gin = 5'h00;
  logic [31:0] pos_count, rd;
  logic [15:0] func;
  logic [1:0] rsp;
  int mismatches = 0;
  int checks_done = 0;
  int steps = 0;

  always #25 clk_sys_i = ~clk_sys_i;

  // Step pulses are counted where they are settled
  always @(negedge clk_sys_i) if (step === 1'b1) steps++;

  cpd_top cpd_top_inst (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .axi_req_i(axi_req), .axi_rsp_o(axi_rsp),
    .pulse_i(pulse), .sign_i(sign), .general_input_i(gin),
    .step_o(step), .step_neg_o(step_neg),
    .position_count_o(pos_count), .func_o(func)
  );

  cpd_host_model cpd_host_model_inst (
    .clk_sys_i(clk_sys_i), .pulse_o(pulse), .sign_o(sign)
  );

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Handshakes are judged at the falling edge, acted on at the rising one
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    b = 1'b0;
    @(posedge clk_sys_i);
    axi_req.awvalid <= 1'b1;
    axi_req.awaddr <= a;
    axi_req.wvalid <= 1'b1;
    axi_req.wdata <= d;
    axi_req.wstrb <= 4'hF;
    axi_req.bready <= 1'b1;
    for (int n = 0; n < 50 && !b; n++) begin
      @(negedge clk_sys_i);
      aw = axi_req.awvalid & axi_rsp.awready;
      w = axi_req.wvalid & axi_rsp.wready;
      b = axi_rsp.bvalid;
      rsp = axi_rsp.bresp;
      @(posedge clk_sys_i);
      if (aw) axi_req.awvalid <= 1'b0;
      if (w) axi_req.wvalid <= 1'b0;
      if (b) axi_req.bready <= 1'b0;
    end
    check("write answer", 32'(b), 32'h0000_0001);
  endtask

  task automatic rd_reg(input logic [7:0] a);
    logic ar, r;
    r = 1'b0;
    @(posedge clk_sys_i);
    axi_req.arvalid <= 1'b1;
    axi_req.araddr <= a;
    axi_req.rready <= 1'b1;
    for (int n = 0; n < 50 && !r; n++) begin
      @(negedge clk_sys_i);
      ar = axi_req.arvalid & axi_rsp.arready;
      r = axi_rsp.rvalid;
      rd = axi_rsp.rdata;
      rsp = axi_rsp.rresp;
      @(posedge clk_sys_i);
      if (ar) axi_req.arvalid <= 1'b0;
      if (r) axi_req.rready <= 1'b0;
    end
    check("read answer", 32'(r), 32'h0000_0001);
  endtask

  // Set format, inversion and mode, then clear the count
  task automatic setup(input logic [1:0] f, input logic inv,
                       input logic [1:0] m);
    wr(cpd_pkg::OFS_CTRL, {26'h000_0000, m, 1'b0, inv, f});
    wr(cpd_pkg::OFS_COUNT, 32'h0000_0000);
    steps = 0;
  endtask

  task automatic t_reset();
    rd_reg(cpd_pkg::OFS_CTRL);
    check("ctrl reset", rd, cpd_pkg::CTRL_RESET);
    rd_reg(cpd_pkg::OFS_COUNT);
    check("count reset", rd, 32'h0000_0000);
    for (int i = 0; i < cpd_pkg::NPIN; i++) begin
      rd_reg(cpd_pkg::OFS_MAP0 + 8'(i * 4));
      check("map reset", rd, cpd_pkg::MAP_RESET[i]);
    end
    rd_reg(8'hFC);
    check("unmapped resp", 32'(rsp), 32'(cpd_pkg::RESP_SLVERR));
    check("unmapped data", rd, 32'h0000_0000);
    wr(8'hFC, 32'h0000_0000);
    check("unmapped wresp", 32'(rsp), 32'(cpd_pkg::RESP_SLVERR));
    wr(cpd_pkg::OFS_CTRL, 32'h0000_0000);
    check("ctrl wresp", 32'(rsp), 32'(cpd_pkg::RESP_OKAY));
  endtask

  // Both quadrature formats, both inversions, one cycle each way
  task automatic t_quad();
    logic inv;
    for (int k = 0; k < 4; k++) begin
      inv = k[0];
      setup(k[1] ? cpd_pkg::FMT_QUAD2 : cpd_pkg::FMT_QUAD0, inv,
            cpd_pkg::MODE_POS);
      cpd_host_model_inst.quad(1'b1);
      repeat (3) @(posedge clk_sys_i);
      check("quad count", pos_count, inv ? 32'h4 : 32'hFFFF_FFFC);
      check("quad steps", 32'(steps), 32'h0000_0004);
      check("quad dir", 32'(step_neg), 32'(!inv));
      cpd_host_model_inst.quad(1'b0);
      repeat (3) @(posedge clk_sys_i);
      check("quad back", pos_count, 32'h0000_0000);
    end
  endtask

  // Two forward and one reverse step in the train formats
  task automatic t_train();
    logic inv;
    logic dual;
    for (int k = 0; k < 4; k++) begin
      inv = k[0];
      dual = ~k[1];
      setup(dual ? cpd_pkg::FMT_DUAL : cpd_pkg::FMT_PDIR, inv,
            cpd_pkg::MODE_POS);
      for (int j = 0; j < 3; j++) begin
        if (dual) cpd_host_model_inst.train(j == 2);
        else cpd_host_model_inst.pdir(j == 2);
      end
      rd_reg(cpd_pkg::OFS_COUNT);
      check("train count", rd, inv ? 32'hFFFF_FFFF : 32'h1);
      check("train steps", 32'(steps), 32'h0000_0003);
    end
  endtask

  // Pulses count in full-closed mode only among the other modes
  task automatic t_mode();
    for (int m = 1; m < 4; m++) begin
      setup(cpd_pkg::FMT_PDIR, 1'b0, 2'(m));
      cpd_host_model_inst.pdir(1'b0);
      cpd_host_model_inst.pdir(1'b0);
      repeat (3) @(posedge clk_sys_i);
      check("mode steps", 32'(steps), m == 1 ? 32'h2 : 32'h0);
      check("mode count", pos_count, m == 1 ? 32'h2 : 32'h0);
    end
  endtask

  // Both phases moving at once is flagged, and cleared by writing one
  task automatic t_perr();
    setup(cpd_pkg::FMT_QUAD0, 1'b0, cpd_pkg::MODE_POS);
    cpd_host_model_inst.put(1'b1, 1'b1);
    cpd_host_model_inst.put(1'b0, 1'b0);
    rd_reg(cpd_pkg::OFS_STATUS);
    check("phase error", 32'(rd[9]), 32'h0000_0001);
    wr(cpd_pkg::OFS_STATUS, 32'h0000_0200);
    rd_reg(cpd_pkg::OFS_STATUS);
    check("phase clear", 32'(rd[9]), 32'h0000_0000);
  endtask

  // Pin 0 carries a different function in each mode group, normally-closed logic in velocity only
  task automatic t_pins();
    int fb;
    logic exp;
    wr(cpd_pkg::OFS_MAP0, 32'h0004_1503);
    rd_reg(cpd_pkg::OFS_MAP0);
    check("map write", rd, 32'h0004_1503 & cpd_pkg::MAP_MASK);
    for (int m = 0; m < 4; m++) begin
      wr(cpd_pkg::OFS_CTRL, {26'h000_0000, 2'(m), 4'h0});
      fb = m < 2 ? 3 : (m == 2 ? 5 : 4);
      for (int lv = 0; lv < 2; lv++) begin
        @(posedge clk_sys_i);
        gin[0] <= lv[0];
        repeat (3) @(posedge clk_sys_i);
        exp = (m == 2) ? ~lv[0] : lv[0];
        check("pin func", 32'(func[fb]), 32'(exp));
      end
    end
    // Raw pin levels show in the status word
    rd_reg(cpd_pkg::OFS_STATUS);
    check("status pins", 32'(rd[4:0]), 32'h0000_0001);
  endtask

  // Main sequence
  initial begin
    repeat (8) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_sys_i);
    t_reset();
    t_quad();
    t_train();
    t_mode();
    t_perr();
    t_pins();
    report_and_stop();
  end

  // Whole run needs a few hundred cycles; this allows far more
  initial begin
    #1000000;
    mismatches++;
    report_and_stop();
  end
endmodule // tb_command_pulse_input_decoder
